// File: acf_pkg.sv
// Purpose: shared constants and types for the converter control slice
// Assumes: classic wishbone slave, 32-bit data, control word in low 16 bits
// Notes: one control word plus a result port
package acf_pkg;
   localparam logic [7:0] ACF_CTRL_OFS = 8'h00;
   localparam logic [7:0] ACF_RESULT_OFS = 8'h04;
   localparam int ACF_ON_BIT = 15;
   localparam int ACF_IDLE_STOP_BIT = 13;
   localparam int ACF_DMA_BM_BIT = 12;
   localparam int ACF_RES_BIT = 10;
   localparam int ACF_FORM_LSB = 8;
   localparam int ACF_TRIG_LSB = 4;
   localparam int ACF_SIMUL_BIT = 3;
   localparam int ACF_AUTO_BIT = 2;
   localparam int ACF_SAMPLE_BIT = 1;
   localparam int ACF_DONE_BIT = 0;
   localparam logic [15:0] ACF_CTRL_RESET = 16'h0000;
   localparam logic [15:0] ACF_CTRL_WMASK = 16'hb7fe;
   localparam logic [31:0] ACF_UNMAPPED_DATA = 32'h0000_0000;

   typedef enum logic [1:0] {
      ACF_FMT_INT = 2'b00,
      ACF_FMT_SINT = 2'b01,
      ACF_FMT_FRAC = 2'b10,
      ACF_FMT_SFRAC = 2'b11
   } acf_fmt_e;

   typedef struct packed {
      logic converter_on;
      logic idle_stop;
      logic dma_build_mode;
      logic resolution_select;
      acf_fmt_e fmt;
   } acf_cfg_s;

   typedef struct packed {
      logic valid;
      logic [11:0] raw;
      logic [1:0] chan;
   } acf_sample_s;

   typedef struct packed {
      logic valid;
      logic [15:0] data;
      logic [1:0] chan;
      logic addr_mode;
   } acf_result_s;
endpackage

// File: acf_format.sv
// Purpose: formats one raw conversion into the output word
// Assumes: raw result right aligned in 12 bits
// Notes: combinational
`timescale 1ns/1ps
`default_nettype none
module acf_format
   import acf_pkg::*;
(
   input wire logic [11:0] raw,
   input wire logic twelve_bit,
   input wire acf_fmt_e fmt,
   output logic [15:0] dout
);
   always_comb begin
      dout = 16'h0000;
      if (twelve_bit) begin
         unique case (fmt)
            ACF_FMT_SFRAC: dout = {~raw[11], raw[10:0], 4'h0};
            ACF_FMT_FRAC: dout = {raw, 4'h0};
            ACF_FMT_SINT: dout = {{5{~raw[11]}}, raw[10:0]};
            ACF_FMT_INT: dout = {4'h0, raw};
         endcase
      end else begin
         unique case (fmt)
            ACF_FMT_SFRAC: dout = {~raw[9], raw[8:0], 6'h00};
            ACF_FMT_FRAC: dout = {raw[9:0], 6'h00};
            ACF_FMT_SINT: dout = {{7{~raw[9]}}, raw[8:0]};
            ACF_FMT_INT: dout = {6'h00, raw[9:0]};
         endcase
      end
   end
endmodule
`default_nettype wire

// File: acf_wb_slave.sv
// Purpose: classic wishbone decode to register strobes
// Assumes: single cycle requests, ack one cycle after stb
// Notes: ack drops the cycle after it is given
`timescale 1ns/1ps
`default_nettype none
module acf_wb_slave
   import acf_pkg::*;
(
   input wire logic mclk,
   input wire logic srst,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   output logic wb_ack_o,
   output logic wr_pulse,
   output logic rd_pulse,
   output logic [7:0] adr
);
   logic ack_r;
   logic go;
   assign go = wb_cyc_i && wb_stb_i && !ack_r;
   assign wr_pulse = go && wb_we_i;
   assign rd_pulse = go && !wb_we_i;
   assign adr = wb_adr_i;
   assign wb_ack_o = ack_r;
   always_ff @(posedge mclk) begin
      if (srst) begin
         ack_r <= 1'b0;
      end else begin
         ack_r <= go;
      end
   end
endmodule
`default_nettype wire

// File: acf_control.sv
// Purpose: converter control word, result formatting and dma addressing
// Assumes: conversion core and dma channel on mclk
// Notes: registered wishbone answer one cycle after request
//
// Register access over Wishbone and the placing of the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
module acf_control
   import acf_pkg::*;
(
   input wire logic mclk,
   input wire logic srst,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic device_idle,
   input wire acf_sample_s sample_in,
   input wire logic sample_start_ack,
   output logic convert_enable,
   output logic twelve_bit_mode,
   output logic sample_request,
   output logic [2:0] trigger_sel,
   output logic simul_sample,
   output acf_result_s result_out
);
   logic [15:0] ctrl_r;
   logic [15:0] ctrl_nxt;
   logic [31:0] rdata_r;
   logic [15:0] last_result_r;
   logic idle_s1_r;
   logic idle_s2_r;
   logic wr_pulse;
   logic rd_pulse;
   logic [7:0] adr;
   logic [15:0] fmt_word;
   logic running;
   logic done_set;
   acf_cfg_s cfg;
   acf_result_s result_r;

   acf_wb_slave u_bus (
      .mclk(mclk),
      .srst(srst),
      .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i),
      .wb_adr_i(wb_adr_i),
      .wb_ack_o(wb_ack_o),
      .wr_pulse(wr_pulse),
      .rd_pulse(rd_pulse),
      .adr(adr)
   );

   assign cfg.converter_on = ctrl_r[ACF_ON_BIT];
   assign cfg.idle_stop = ctrl_r[ACF_IDLE_STOP_BIT];
   assign cfg.dma_build_mode = ctrl_r[ACF_DMA_BM_BIT];
   assign cfg.resolution_select = ctrl_r[ACF_RES_BIT];
   assign cfg.fmt = acf_fmt_e'(ctrl_r[ACF_FORM_LSB +: 2]);

   // idle comes from outside the clock domain
   always_ff @(posedge mclk) begin
      if (srst) begin
         idle_s1_r <= 1'b0;
         idle_s2_r <= 1'b0;
      end else begin
         idle_s1_r <= device_idle;
         idle_s2_r <= idle_s1_r;
      end
   end

   assign running = cfg.converter_on && !(cfg.idle_stop && idle_s2_r);
   assign convert_enable = running;
   assign twelve_bit_mode = cfg.resolution_select;
   assign sample_request = ctrl_r[ACF_SAMPLE_BIT];
   assign trigger_sel = ctrl_r[ACF_TRIG_LSB +: 3];
   assign simul_sample = ctrl_r[ACF_SIMUL_BIT];
   assign done_set = running && sample_in.valid;

   acf_format u_fmt (
      .raw(sample_in.raw),
      .twelve_bit(cfg.resolution_select),
      .fmt(cfg.fmt),
      .dout(fmt_word)
   );

   // control word: software write, then hardware set and clear win
   always_comb begin
      ctrl_nxt = ctrl_r;
      if (wr_pulse && adr == ACF_CTRL_OFS) begin
         if (wb_sel_i[0]) begin
            ctrl_nxt[7:1] = wb_dat_i[7:1];
            // done is clear-only from software
            if (!wb_dat_i[ACF_DONE_BIT]) begin
               ctrl_nxt[ACF_DONE_BIT] = 1'b0;
            end
         end
         if (wb_sel_i[1]) begin
            ctrl_nxt[15:8] = wb_dat_i[15:8];
         end
         ctrl_nxt = ctrl_nxt & (ACF_CTRL_WMASK | 16'h0001);
      end
      if (sample_start_ack) begin
         ctrl_nxt[ACF_SAMPLE_BIT] = 1'b0;
      end
      if (running && ctrl_r[ACF_AUTO_BIT] && !ctrl_r[ACF_SAMPLE_BIT]) begin
         ctrl_nxt[ACF_SAMPLE_BIT] = 1'b1;
      end
      if (done_set) begin
         ctrl_nxt[ACF_DONE_BIT] = 1'b1;
      end
      if (!cfg.converter_on) begin
         ctrl_nxt[ACF_SAMPLE_BIT] = ctrl_nxt[ACF_SAMPLE_BIT] & ctrl_nxt[ACF_ON_BIT];
      end
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         ctrl_r <= ACF_CTRL_RESET;
      end else begin
         ctrl_r <= ctrl_nxt;
      end
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         result_r <= '0;
         last_result_r <= 16'h0000;
      end else begin
         result_r.valid <= done_set;
         if (done_set) begin
            result_r.data <= fmt_word;
            last_result_r <= fmt_word;
            result_r.addr_mode <= cfg.dma_build_mode;
            if (cfg.dma_build_mode) begin
               result_r.chan <= 2'b00;
            end else if (cfg.resolution_select) begin
               result_r.chan <= 2'b00;
            end else begin
               result_r.chan <= sample_in.chan;
            end
         end
      end
   end
   assign result_out = result_r;

   // registered read data, unmapped reads answer zero
   always_ff @(posedge mclk) begin
      if (srst) begin
         rdata_r <= ACF_UNMAPPED_DATA;
      end else if (rd_pulse) begin
         unique case (adr)
            ACF_CTRL_OFS: rdata_r <= {16'h0000, ctrl_r & (ACF_CTRL_WMASK | 16'h0001)};
            ACF_RESULT_OFS: rdata_r <= {16'h0000, last_result_r};
            default: rdata_r <= ACF_UNMAPPED_DATA;
         endcase
      end
   end
   assign wb_dat_o = rdata_r;
endmodule
`default_nettype wire

// File: acf_control_checker.sv
// Purpose: port assertions for acf_control
// Assumes: ack one cycle after a taken request
// Notes: bind after the module
`timescale 1ns/1ps
`default_nettype none
module acf_control_checker
   import acf_pkg::*;
(
   input wire logic mclk,
   input wire logic srst,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic convert_enable,
   input wire logic twelve_bit_mode,
   input wire acf_result_s result_out
);
   default clocking @(posedge mclk); endclocking
   default disable iff (srst);
   logic wr_hi;
   assign wr_hi = wb_cyc_i & wb_stb_i & ~wb_ack_o & wb_we_i & wb_sel_i[1] & (wb_adr_i == 8'h00);
   chk_ack_one: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("ack late");
   chk_ack_drop: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
   chk_reset_zero: assert property ($fell(srst) |-> !convert_enable && !result_out.valid)
      else $error("outputs not zero after reset");
   chk_off_write: assert property (wr_hi && !wb_dat_i[15] |=> !convert_enable)
      else $error("converter still on");
   chk_res_write: assert property (wr_hi |=> twelve_bit_mode == $past(wb_dat_i[10]))
      else $error("resolution not taken");
   chk_result_on: assert property (result_out.valid |-> $past(convert_enable))
      else $error("result while stopped");
   chk_chan_zero: assert property (result_out.valid && (result_out.addr_mode || twelve_bit_mode)
      |-> result_out.chan == 2'h0) else $error("channel address wrong");
   chk_gap_bits: assert property (wb_ack_o && !$past(wb_we_i) && $past(wb_adr_i) == 8'h00
      |-> !wb_dat_o[14] && !wb_dat_o[11]) else $error("unused bits set");
endmodule
bind acf_control acf_control_checker chk_u (.*);
`default_nettype wire

// File: acf_core_model.sv
// Purpose: conversion core stand-in
// Assumes: fire pulses one cycle
// Notes: idle data lines toggle
`timescale 1ns/1ps
`default_nettype none
module acf_core_model
   import acf_pkg::*;
(
   input wire logic mclk,
   input wire logic fire,
   input wire logic [11:0] raw,
   input wire logic [1:0] chan,
   output acf_sample_s sample_in
);
   // data inverts each cycle outside valid, so a stale value only returns every second cycle
   always_ff @(posedge mclk) begin
      sample_in <= {fire, fire ? raw : ~sample_in.raw, fire ? chan : ~sample_in.chan};
   end
endmodule
`default_nettype wire

// File: test_acf_control.sv
// Purpose: acf_control bench
// Assumes: core model returns each fired sample
// Notes: one task per scenario
`timescale 1ns/1ps
`default_nettype none
module test_acf_control
   import acf_pkg::*;
;
   localparam logic [15:0] EXP [8] = '{16'h02a5, 16'h00a5, 16'ha940, 16'h2940,
      16'h05a3, 16'hfda3, 16'h5a30, 16'hda30};
   logic mclk = 1'b0, srst = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
   logic device_idle = 1'b0, fire = 1'b0, sample_start_ack = 1'b0;
   logic wb_ack_o, convert_enable, twelve_bit_mode;
   logic sample_request, simul_sample;
   logic [2:0] trigger_sel;
   logic [7:0] wb_adr_i = 8'h00;
   logic [3:0] wb_sel_i = 4'h3;
   logic [31:0] wb_dat_i = 32'h0000_0000, wb_dat_o;
   logic [11:0] raw = 12'h000;
   logic [1:0] chan = 2'h0;
   acf_sample_s sample_in;
   acf_result_s result_out;
   int bad_count = 0, compares = 0;
   acf_control dut_u (.*);
   acf_core_model core_u (.*);
   initial forever #5 mclk = ~mclk;
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) bad_count++;
      if (seen !== exp) $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
   endtask
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk);
      {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, w, a, d};
      for (int n = 0; n < 20 && wb_ack_o !== 1'b1; n++) @(posedge mclk);
      check(wb_ack_o, 1'b1);
      {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'b000;
   endtask
   task automatic fire_get(input logic [11:0] x, input logic [1:0] c);
      @(posedge mclk);
      {fire, raw, chan} <= {1'b1, x, c};
      @(posedge mclk);
      fire <= 1'b0;
      for (int n = 0; n < 6 && result_out.valid !== 1'b1; n++) @(posedge mclk);
      check(result_out.valid, 1'b1);
   endtask
   task automatic t_regs;
      wb(1'b0, ACF_CTRL_OFS, 32'h0000_0000);
      check(wb_dat_o, ACF_CTRL_RESET);
      wb(1'b1, ACF_CTRL_OFS, 32'h0000_7f00);
      wb(1'b0, ACF_CTRL_OFS, 32'h0000_0000);
      check(wb_dat_o, 32'h0000_3700);
      wb(1'b0, 8'h10, 32'h0000_0000);
      check(wb_dat_o, ACF_UNMAPPED_DATA);
   endtask
   task automatic t_fmt;
      for (int i = 0; i < 8; i++) begin
         wb(1'b1, ACF_CTRL_OFS, 32'h0000_8000 | (i[2:0] << 8));
         fire_get(i[2] ? 12'h5a3 : 12'h2a5, 2'h3);
         check(result_out.data, EXP[i]);
         check({twelve_bit_mode, result_out.addr_mode, result_out.chan}, i[2] ? 4'h8 : 4'h3);
      end
   endtask
   task automatic t_dma;
      wb(1'b1, ACF_CTRL_OFS, 32'h0000_9000);
      fire_get(12'h2a5, 2'h2);
      check({result_out.addr_mode, result_out.chan}, 3'h4);
      wb(1'b0, ACF_CTRL_OFS, 32'h0000_0000);
      check(wb_dat_o, 32'h0000_9001);
      wb(1'b0, ACF_RESULT_OFS, 32'h0000_0000);
      check(wb_dat_o, 32'h0000_02a5);
   endtask
   task automatic t_idle;
      wb(1'b1, ACF_CTRL_OFS, 32'h0000_a000);
      device_idle <= 1'b1;
      repeat (4) @(posedge mclk);
      check(convert_enable, 1'b0);
      {fire, raw, chan} <= {1'b1, 12'h2a5, 2'h1};
      @(posedge mclk);
      fire <= 1'b0;
      repeat (3) @(posedge mclk) check(result_out.valid, 1'b0);
      wb(1'b1, ACF_CTRL_OFS, 32'h0000_8000);
      repeat (2) @(posedge mclk);
      check(convert_enable, 1'b1);
   endtask
   task automatic t_auto;
      wb(1'b1, ACF_CTRL_OFS, 32'h0000_805d);
      @(posedge mclk);
      check({trigger_sel, simul_sample, sample_request}, 5'h17);
      sample_start_ack <= 1'b1;
      @(posedge mclk);
      sample_start_ack <= 1'b0;
      @(posedge mclk);
      check(sample_request, 1'b0);
      @(posedge mclk);
      check(sample_request, 1'b1);
      wb(1'b1, ACF_CTRL_OFS, 32'h0000_0001);
      check(convert_enable, 1'b0);
   endtask
   task automatic test_done;
      $display("compares=%0d bad_count=%0d", compares, bad_count);
      if (bad_count == 0 && compares > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   initial begin
      #100_000;
      bad_count++;
      test_done();
   end
   initial begin
      repeat (12) @(posedge mclk);
      srst <= 1'b0;
      t_regs();
      t_fmt();
      t_dma();
      t_idle();
      t_auto();
      test_done();
   end
endmodule
`default_nettype wire
